/* File: rtl/ccl_pkg.sv */
// Functional notes
// - Raw result high when positive exceeds negative.
// - Raw result XOR invert bit drives output.
// - Output holds preset level during startup.
// - Hysteresis off or one of three levels.
// - Positive selects pins; negative adds reference.
// - Reference code drives divider, code over 256.
// - Power profile field selects speed versus current.
// - Output exported as asynchronous level event.
// - Block consumes no events from fabric.
// - Edge select picks rising, falling or both.
// - Matching edge sets flag regardless of enable.
// - Request equals enable and flag, until cleared.
// - Idle sleep behaves exactly as active.
// - Standby disables unless run-in-standby is set.
// - Power-down disables comparator and pad drive.
// - Registers at 0x00, 0x02, 0x05, 0x06, 0x07.
// - Edge codes: both 0, falling 2, rising 3.
// - Write one clears flag; zero ignored.
// - Output state bit lags three clock cycles.
package ccl_pkg;

	// ****************************************************************
	// Register offsets and widths
	// ****************************************************************
	localparam int CCL_AW = 3;
	localparam logic [2:0] CCL_OFF_MAIN = 3'h0;
	localparam logic [2:0] CCL_OFF_INSEL = 3'h2;
	localparam logic [2:0] CCL_OFF_REF = 3'h5;
	localparam logic [2:0] CCL_OFF_IRQ = 3'h6;
	localparam logic [2:0] CCL_OFF_FLAG = 3'h7;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [7:0] CCL_RST_MAIN = 8'h00;
	localparam logic [7:0] CCL_RST_INSEL = 8'h00;
	localparam logic [7:0] CCL_RST_REF = 8'hFF;
	localparam logic [7:0] CCL_RST_IRQ = 8'h00;
	localparam logic [7:0] CCL_ZERO = 8'h00;

	// ****************************************************************
	// Field codes
	// ****************************************************************
	localparam logic [1:0] CCL_EDGE_ANY = 2'h0;
	localparam logic [1:0] CCL_EDGE_FALL = 2'h2;
	localparam logic [1:0] CCL_EDGE_RISE = 2'h3;
	localparam logic [2:0] CCL_POS_PIN3 = 3'h3;
	localparam logic [2:0] CCL_POS_PIN4 = 3'h4;
	localparam logic [2:0] CCL_NEG_PIN2 = 3'h2;
	localparam logic [2:0] CCL_NEG_PIN3 = 3'h3;
	localparam logic [2:0] CCL_NEG_REF = 3'h4;

	// ****************************************************************
	// Startup time of the analog core
	// ****************************************************************
	localparam int CCL_CLK_MHZ = 40;
	localparam int CCL_STARTUP_NS = 1000;
	localparam int CCL_STARTUP_CYC = (CCL_STARTUP_NS * CCL_CLK_MHZ + 999) / 1000;
	localparam logic [7:0] CCL_STARTUP_LAST = 8'(CCL_STARTUP_CYC - 1);

	// ****************************************************************
	// Register layouts
	// ****************************************************************
	typedef struct packed {
		logic run_in_standby;
		logic pad_drive_enable;
		logic unused5;
		logic [1:0] power_profile;
		logic [1:0] hysteresis_level;
		logic enable;
	} ccl_main_t;

	typedef struct packed {
		logic invert;
		logic output_preset;
		logic [2:0] positive_selector;
		logic [2:0] negative_selector;
	} ccl_insel_t;

	typedef struct packed {
		logic [1:0] edge_select;
		logic compare_irq_enable;
	} ccl_irq_t;

	// Settings handed to the analog core.
	typedef struct packed {
		logic core_enable;
		logic [1:0] power_profile;
		logic [1:0] hysteresis_level;
		logic [1:0] pos_pin_input;
		logic [2:0] neg_pin_input;
		logic [7:0] divided_reference;
	} ccl_analog_t;

	typedef enum logic [1:0] {
		CCL_SLEEP_ACTIVE,
		CCL_SLEEP_IDLE,
		CCL_SLEEP_STANDBY,
		CCL_SLEEP_PDOWN
	} ccl_sleep_t;

	typedef enum {
		CCL_ST_OFF,
		CCL_ST_START,
		CCL_ST_RUN
	} ccl_state_t;

endpackage

/* File: rtl/ccl_comparator_ctrl.sv */
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
module ccl_comparator_ctrl
	import ccl_pkg::*;
(
	// Clock and reset.
	input wire logic clock_i,
	input wire logic rst_i,
	// Register port.
	input wire logic [CCL_AW-1:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	// Analog core.
	input wire logic raw_compare_i,
	output ccl_analog_t analog_o,
	// Sleep state from the power manager.
	input wire ccl_sleep_t sleep_i,
	// Pin, event and interrupt.
	output logic pad_out_o,
	output logic pad_oe_o,
	output logic event_o,
	output logic irq_o
);

	// ****************************************************************
	// Registers
	// ****************************************************************
	ccl_main_t main_r;
	ccl_insel_t insel_r;
	logic [7:0] ref_r;
	ccl_irq_t irq_r;
	logic flag_r;
	logic [2:0] sync_r;
	logic prev_r;
	logic seen_r;
	logic [7:0] start_cnt_r;
	ccl_state_t state_r;
	ccl_state_t state_nxt;
	logic [7:0] rdata_r;
	logic pad_out_r;
	logic pad_oe_r;
	logic irq_r_o;
	ccl_analog_t analog_r;

	// ****************************************************************
	// Decode
	// ****************************************************************
	wire logic wr_main = wr_i && (addr_i == CCL_OFF_MAIN);
	wire logic wr_insel = wr_i && (addr_i == CCL_OFF_INSEL);
	wire logic wr_ref = wr_i && (addr_i == CCL_OFF_REF);
	wire logic wr_irq = wr_i && (addr_i == CCL_OFF_IRQ);
	wire logic wr_flag = wr_i && (addr_i == CCL_OFF_FLAG);
	// Reserved bits of written data are dropped on entry.
	wire ccl_main_t main_w = ccl_main_t'({wdata_i[7:6], 1'b0, wdata_i[4:0]});
	wire ccl_irq_t irq_w = ccl_irq_t'({wdata_i[5:4], wdata_i[0]});

	// ****************************************************************
	// Sleep gating
	// ****************************************************************
	// Idle behaves as active; standby needs run_in_standby; power-down stops all but the flag and request.
	wire logic sleep_ok = (sleep_i == CCL_SLEEP_ACTIVE) || (sleep_i == CCL_SLEEP_IDLE)
		|| ((sleep_i == CCL_SLEEP_STANDBY) && main_r.run_in_standby);
	wire logic running = main_r.enable && sleep_ok;

	// Reserved selector codes leave the core off rather than pick a pin.
	wire logic pos_ok = (insel_r.positive_selector == CCL_POS_PIN3)
		|| (insel_r.positive_selector == CCL_POS_PIN4);
	wire logic neg_ok = (insel_r.negative_selector == CCL_NEG_PIN2)
		|| (insel_r.negative_selector == CCL_NEG_PIN3)
		|| (insel_r.negative_selector == CCL_NEG_REF);

	// ****************************************************************
	// Output conditioning
	// ****************************************************************
	// The enabled core drives raw_compare_i high only when positive exceeds negative.
	wire logic settled = (state_r == CCL_ST_RUN);
	wire logic cond_out = settled ? (raw_compare_i ^ insel_r.invert)
		: insel_r.output_preset;
	wire logic live_out = running && cond_out;

	// Level event, combinational from the analog result, no clock needed.
	assign event_o = live_out;

	// Edge detection on the synchronized level.
	wire logic samp = sync_r[2];
	wire logic rise = seen_r && samp && !prev_r;
	wire logic fall = seen_r && !samp && prev_r;
	wire logic edge_hit = (irq_r.edge_select == CCL_EDGE_ANY) ? (rise || fall)
		: (irq_r.edge_select == CCL_EDGE_FALL) ? fall
		: (irq_r.edge_select == CCL_EDGE_RISE) ? rise : 1'b0;
	// A new edge wins over a clear in the same cycle.
	wire logic flag_nxt = edge_hit || (flag_r && !(wr_flag && wdata_i[0]));
	// The request follows a disable in the cycle of the write, like it follows a clear.
	wire logic irq_en_nxt = wr_irq ? irq_w.compare_irq_enable : irq_r.compare_irq_enable;

	// ****************************************************************
	// Startup sequencer
	// ****************************************************************
	wire logic start_done = (start_cnt_r == CCL_STARTUP_LAST);
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			CCL_ST_OFF: begin
				if (running && pos_ok && neg_ok) begin
					state_nxt = CCL_ST_START;
				end
			end
			CCL_ST_START: begin
				if (!running) begin
					state_nxt = CCL_ST_OFF;
				end else if (start_done) begin
					state_nxt = CCL_ST_RUN;
				end
			end
			CCL_ST_RUN: begin
				if (!running) begin
					state_nxt = CCL_ST_OFF;
				end
			end
		endcase
	end

	// State and startup counter.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			state_r <= CCL_ST_OFF;
			start_cnt_r <= CCL_ZERO;
		end else begin
			state_r <= state_nxt;
			start_cnt_r <= (state_r == CCL_ST_START) ? start_cnt_r + 8'h01 : CCL_ZERO;
		end
	end

	// ****************************************************************
	// Register writes
	// ****************************************************************
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			main_r <= ccl_main_t'(CCL_RST_MAIN);
			insel_r <= ccl_insel_t'(CCL_RST_INSEL);
			ref_r <= CCL_RST_REF;
			irq_r <= ccl_irq_t'(3'h0);
		end else begin
			if (wr_main) main_r <= main_w;
			if (wr_insel) insel_r <= ccl_insel_t'(wdata_i);
			if (wr_ref) ref_r <= wdata_i;
			if (wr_irq) irq_r <= irq_w;
		end
	end

	// ****************************************************************
	// Synchronizer, edge history and flag
	// ****************************************************************
	// Three stages give the documented three-cycle lag of the state bit.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			sync_r <= 3'h0;
			prev_r <= 1'b0;
			seen_r <= 1'b0;
			flag_r <= 1'b0;
		end else begin
			sync_r <= {sync_r[1:0], live_out};
			prev_r <= samp;
			seen_r <= 1'b1;
			flag_r <= flag_nxt;
		end
	end

	// ****************************************************************
	// Read data, one cycle after the strobe
	// ****************************************************************
	wire logic [7:0] rd_mux = (addr_i == CCL_OFF_MAIN) ? 8'(main_r)
		: (addr_i == CCL_OFF_INSEL) ? 8'(insel_r)
		: (addr_i == CCL_OFF_REF) ? ref_r
		: (addr_i == CCL_OFF_IRQ) ? {2'h0, irq_r.edge_select, 3'h0, irq_r.compare_irq_enable}
		: (addr_i == CCL_OFF_FLAG) ? {3'h0, samp, 3'h0, flag_r}
		: CCL_ZERO;
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_r <= CCL_ZERO;
		end else begin
			rdata_r <= rd_i ? rd_mux : CCL_ZERO;
		end
	end
	assign rdata_o = rdata_r;

	// ****************************************************************
	// Registered outputs
	// ****************************************************************
	// Pad and request are registered; the pad follows the live level one cycle late.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			pad_out_r <= 1'b0;
			pad_oe_r <= 1'b0;
			irq_r_o <= 1'b0;
			analog_r <= '0;
		end else begin
			pad_out_r <= live_out;
			pad_oe_r <= main_r.pad_drive_enable && running;
			irq_r_o <= irq_en_nxt && flag_nxt;
			analog_r.core_enable <= running && pos_ok && neg_ok;
			analog_r.power_profile <= main_r.power_profile;
			analog_r.hysteresis_level <= main_r.hysteresis_level;
			analog_r.pos_pin_input <= {insel_r.positive_selector == CCL_POS_PIN4,
				insel_r.positive_selector == CCL_POS_PIN3};
			analog_r.neg_pin_input <= {insel_r.negative_selector == CCL_NEG_REF,
				insel_r.negative_selector == CCL_NEG_PIN3,
				insel_r.negative_selector == CCL_NEG_PIN2};
			analog_r.divided_reference <= ref_r;
		end
	end
	assign pad_out_o = pad_out_r;
	assign pad_oe_o = pad_oe_r;
	assign irq_o = irq_r_o;
	assign analog_o = analog_r;

endmodule

/* File: testbench/ccl_comparator_ctrl_asserts.sv */
`timescale 1ns/1ps
module ccl_comparator_ctrl_asserts
	import ccl_pkg::*;
(
	// Clock and reset.
	input wire logic clock_i,
	input wire logic rst_i,
	// Register port.
	input wire logic [CCL_AW-1:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	// Core, sleep, pin, event and interrupt.
	input wire logic raw_compare_i,
	input wire ccl_analog_t analog_o,
	input wire ccl_sleep_t sleep_i,
	input wire logic pad_out_o,
	input wire logic pad_oe_o,
	input wire logic event_o,
	input wire logic irq_o
);
	// ****
	// Properties
	// ****
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	// A write to one offset, the first step of several checks.
	sequence wr_at(logic [2:0] a);
		wr_i && addr_i == a;
	endsequence
	// Read data stand one cycle only, so a late consumer sees zero.
	rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("read data not idle");
	rsvd_read_a: assert property (rd_i && addr_i inside {3'h1, 3'h3, 3'h4} |=> !rdata_o)
		else $error("reserved offset read nonzero");
	// The request may only fall through a register write.
	irq_hold_a: assert property (irq_o && !wr_i && sleep_i == CCL_SLEEP_ACTIVE |=> irq_o)
		else $error("interrupt dropped by itself");
	zero_write_a: assert property (irq_o ##0 wr_at(CCL_OFF_FLAG) ##0 !wdata_i[0] |=> irq_o)
		else $error("zero write cleared flag");
	irq_off_a: assert property (wr_at(CCL_OFF_IRQ) ##0 !wdata_i[0] |=> !irq_o)
		else $error("interrupt with enable off");
	// Power-down wins over the enable, run-in-standby and pad drive bits.
	pdown_pad_a: assert property ((sleep_i == CCL_SLEEP_PDOWN) [*2] |-> !pad_oe_o)
		else $error("pad driven in power-down");
	event_pad_a: assert property (pad_oe_o && $past(pad_oe_o) |-> pad_out_o == $past(event_o))
		else $error("pad and event disagree");
	// Settings reach the core one cycle after the register.
	ref_code_a: assert property (wr_at(CCL_OFF_REF) |-> ##2
		analog_o.divided_reference == $past(wdata_i, 2))
		else $error("reference code not passed on");
	hyst_prof_a: assert property (wr_at(CCL_OFF_MAIN)
		##0 (sleep_i == CCL_SLEEP_ACTIVE) [*3] |->
		{analog_o.power_profile, analog_o.hysteresis_level} == $past(wdata_i[4:1], 2))
		else $error("profile or hysteresis not passed on");
endmodule
bind ccl_comparator_ctrl ccl_comparator_ctrl_asserts ccl_comparator_ctrl_asserts_i (
	.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
	.rd_i(rd_i), .rdata_o(rdata_o), .raw_compare_i(raw_compare_i), .analog_o(analog_o),
	.sleep_i(sleep_i), .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o), .event_o(event_o),
	.irq_o(irq_o));

/* File: testbench/ccl_analog_model.sv */
`timescale 1ns/1ps
module ccl_analog_model
	import ccl_pkg::*;
(
	// Clock and core settings.
	input wire logic clock_i,
	input wire ccl_analog_t analog_i,
	// Voltages in mV: positive pins 4 and 3, negative pin, reference.
	input wire logic [1:0][11:0] pos_i,
	input wire logic [11:0] neg_i,
	input wire logic [11:0] vref_i,
	// Raw compare result.
	output logic raw_o
);
	logic [19:0] vdiv;
	logic [11:0] vp;
	logic [11:0] vn;
	logic noise_r = 1'b0;
	// One-hot selectors pick the inputs; the divider gives code/256 of the reference.
	assign vdiv = 20'(analog_i.divided_reference) * 20'(vref_i);
	assign vp = analog_i.pos_pin_input[1] ? pos_i[1] : pos_i[0];
	assign vn = analog_i.neg_pin_input[2] ? vdiv[19:8] : neg_i;
	// An unpowered core chatters, so the block must never pass it on; after a reserved selector write it does, in CCL_ST_RUN.
	always_ff @(posedge clock_i) begin
		noise_r <= ~noise_r;
	end
	assign raw_o = analog_i.core_enable ? (vp > vn) : noise_r;
endmodule

/* File: testbench/ccl_comparator_ctrl_tb_top.sv */
`timescale 1ns/1ps
module ccl_comparator_ctrl_tb_top
	import ccl_pkg::*;
;
	logic clock_i;
	logic rst_i = 1'b1;
	logic [CCL_AW-1:0] addr_i = 3'h0;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [7:0] rdata_o;
	logic raw;
	ccl_analog_t analog;
	ccl_sleep_t sleep_i = CCL_SLEEP_ACTIVE;
	logic pad_out_o;
	logic pad_oe_o;
	logic event_o;
	logic irq_o;
	logic [1:0][11:0] pos = {12'd0, 12'd500};
	int mismatches = 0;
	int compares = 0;
	// ****
	// Design, core model, clock and watchdog
	// ****
	ccl_comparator_ctrl ccl_comparator_ctrl_i (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .raw_compare_i(raw),
		.analog_o(analog), .sleep_i(sleep_i), .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o),
		.event_o(event_o), .irq_o(irq_o));
	ccl_analog_model ccl_analog_model_i (.clock_i(clock_i), .analog_i(analog), .pos_i(pos),
		.neg_i(12'd800), .vref_i(12'd2000), .raw_o(raw));
	initial begin
		clock_i = 1'b0;
		forever #12.5 clock_i = ~clock_i;
	end
	// The tests need well under a thousand cycles.
	initial begin
		#200000;
		mismatches++;
		stop_test();
	end
	// ****
	// Bus tasks and compare
	// ****
	// Strobes stay up so that back-to-back calls never assign twice in one step.
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		wr_i <= 1'b1;
		rd_i <= 1'b0;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clock_i);
	endtask
	task automatic idle(input int n);
		wr_i <= 1'b0;
		rd_i <= 1'b0;
		repeat (n) @(posedge clock_i);
		// Step off the edge so that checks see settled outputs.
		#1;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
		rd_i <= 1'b1;
		wr_i <= 1'b0;
		addr_i <= a;
		@(posedge clock_i);
		#1;
		chk(rdata_o & m, e);
	endtask
	task automatic stop_test();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// ****
	// Scenarios
	// ****
	task automatic t_reset();
		logic [7:0] e [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00};
		chk(analog.divided_reference, 8'hFF);
		chk(8'({pad_oe_o, pad_out_o, event_o, irq_o}), 8'h00);
		for (int a = 0; a < 8; a++) begin
			rd(3'(a), 8'hFF, e[a]);
		end
		$display("reset test done");
	endtask
	// Reserved offsets and bits swallow writes; writes go back to back.
	task automatic t_regs();
		logic [7:0] e [7] = '{8'hDF, 8'h00, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'h31};
		for (int a = 0; a < 7; a++) begin
			wr(3'(a), 8'hFF);
		end
		for (int a = 0; a < 7; a++) begin
			rd(3'(a), 8'hFF, e[a]);
		end
		wr(CCL_OFF_MAIN, 8'h00);
		idle(2);
		chk(8'(pad_oe_o), 8'h00);
		$display("register test done");
	endtask
	// Preset high while the core says low; then compare, invert, event.
	task automatic t_start();
		wr(CCL_OFF_REF, 8'h80);
		wr(CCL_OFF_INSEL, 8'h5C);
		wr(CCL_OFF_MAIN, 8'h41);
		idle(10);
		chk(8'(pad_out_o), 8'h01);
		idle(40);
		chk(8'({pad_oe_o, pad_out_o, event_o}), 8'h04);
		chk(8'({analog.core_enable, analog.pos_pin_input, analog.neg_pin_input}), 8'h2C);
		chk(analog.divided_reference, 8'h80);
		pos[0] <= 12'd1500;
		idle(2);
		chk(8'({pad_oe_o, pad_out_o, event_o}), 8'h07);
		wr(CCL_OFF_INSEL, 8'hDC);
		idle(2);
		chk(8'({pad_oe_o, pad_out_o, event_o}), 8'h04);
		wr(CCL_OFF_INSEL, 8'h5C);
		pos[0] <= 12'd500;
		idle(6);
		wr(CCL_OFF_FLAG, 8'h01);
		$display("startup test done");
	endtask
	task automatic t_edges();
		logic [1:0] md [3] = '{2'h0, 2'h2, 2'h3};
		foreach (md[i]) begin
			wr(CCL_OFF_IRQ, {2'b00, md[i], 4'h1});
			pos[0] <= 12'd1500;
			idle(8);
			rd(CCL_OFF_FLAG, 8'h01, 8'(md[i] != 2'h2));
			chk(8'(irq_o), 8'(md[i] != 2'h2));
			wr(CCL_OFF_FLAG, 8'h01);
			pos[0] <= 12'd500;
			idle(8);
			rd(CCL_OFF_FLAG, 8'h01, 8'(md[i] != 2'h3));
			wr(CCL_OFF_FLAG, 8'h01);
		end
		wr(CCL_OFF_IRQ, 8'h00);
		pos[0] <= 12'd1500;
		idle(8);
		chk(8'(irq_o), 8'h00);
		rd(CCL_OFF_FLAG, 8'h01, 8'h01);
		wr(CCL_OFF_IRQ, 8'h01);
		idle(2);
		wr(CCL_OFF_FLAG, 8'h00);
		idle(2);
		chk(8'(irq_o), 8'h01);
		wr(CCL_OFF_IRQ, 8'h00);
		idle(1);
		chk(8'(irq_o), 8'h00);
		wr(CCL_OFF_IRQ, 8'h01);
		wr(CCL_OFF_FLAG, 8'h01);
		idle(2);
		chk(8'(irq_o), 8'h00);
		$display("edge test done");
	endtask
	// The state bit must lag the output, then follow it.
	task automatic t_status();
		pos[0] <= 12'd500;
		rd(CCL_OFF_FLAG, 8'h10, 8'h10);
		idle(1);
		rd(CCL_OFF_FLAG, 8'h10, 8'h10);
		rd(CCL_OFF_FLAG, 8'h10, 8'h00);
		$display("status test done");
	endtask
	task automatic t_sleep();
		sleep_i <= CCL_SLEEP_IDLE;
		pos[0] <= 12'd1500;
		idle(3);
		chk(8'({pad_oe_o, pad_out_o, event_o}), 8'h07);
		sleep_i <= CCL_SLEEP_ACTIVE;
		wr(CCL_OFF_MAIN, 8'hC1);
		sleep_i <= CCL_SLEEP_STANDBY;
		pos[0] <= 12'd500;
		idle(3);
		chk(8'({pad_oe_o, pad_out_o, event_o}), 8'h04);
		sleep_i <= CCL_SLEEP_ACTIVE;
		wr(CCL_OFF_MAIN, 8'h41);
		sleep_i <= CCL_SLEEP_STANDBY;
		idle(3);
		chk(8'(pad_oe_o), 8'h00);
		sleep_i <= CCL_SLEEP_ACTIVE;
		wr(CCL_OFF_MAIN, 8'hC1);
		sleep_i <= CCL_SLEEP_PDOWN;
		pos[0] <= 12'd1500;
		idle(3);
		chk(8'({pad_oe_o, event_o, analog.core_enable}), 8'h00);
		sleep_i <= CCL_SLEEP_ACTIVE;
		$display("sleep test done");
	endtask
	// ****
	// Main sequence
	// ****
	initial begin
		repeat (12) @(posedge clock_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		t_reset();
		t_regs();
		t_start();
		t_edges();
		t_status();
		t_sleep();
		stop_test();
	end
endmodule
